// ===== pbd_top.sv
// predicted branch decoder with avalon register slave and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "pbd_map.svh"
module pbd_top
  import pbd_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [63:0] instr_pc,
  input wire logic [3:0] flags32,
  input wire logic [3:0] flags64,
  input wire logic [63:0] reg_value,
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic res_valid,
  output logic br_taken,
  output logic [63:0] br_target,
  output logic annul_delay,
  output logic predict_hint,
  output logic illegal_trap,
  output logic prefetch_hint,
  output logic [4:0] source_register_index,
  output logic irq
);
  pbd_state_s q;
  pbd_state_s d;
  pbd_dec_if dif ();

  pbd_cond_eval u_eval (
    .dif(dif.eval)
  );
  pbd_target u_target (
    .dif(dif.tgt)
  );

  assign dif.word = instr_word;
  assign dif.pc = instr_pc;
  assign dif.flags32 = flags32;
  assign dif.flags64 = flags64;
  assign dif.reg_val = reg_value;

  logic recog;
  logic uncond;
  logic annul_bit;
  logic taken;
  logic bus_go;
  logic [2:0] ev;
  logic [2:0] rd_clr;
  logic [31:0] rdata;

  always_comb begin
    d = q;
    recog = instr_valid && q.ctrl[`PBD_CTRL_EN] && (dif.is_flag || dif.is_reg);
    uncond = dif.is_flag &&
             dif.word[`PBD_COND_HI-1:`PBD_COND_LO] == `PBD_COND_NEVER;
    annul_bit = instr_word[`PBD_ANNUL_BIT];
    taken = dif.cond_true && !dif.illegal;
    // results update together, one cycle after the word is seen
    d.res_valid = recog;
    if (recog) begin
      d.taken = taken;
      d.target = dif.target;
      if (dif.illegal) begin
        d.annul = 1'b0;
      end else if (uncond) begin
        d.annul = annul_bit;
      end else begin
        d.annul = taken ? 1'b0 : annul_bit;
      end
      // the hint is passed along only; nothing above looks at it
      d.hint = instr_word[`PBD_PREDICT_BIT];
      d.illegal = dif.illegal;
      d.prefetch = uncond && !instr_word[`PBD_COND_HI] && !dif.illegal &&
                   q.ctrl[`PBD_CTRL_PF];
      d.src_idx = dif.is_reg ? instr_word[`PBD_SRC_HI:`PBD_SRC_LO] : 5'h0;
    end else begin
      d.taken = 1'b0;
      d.annul = 1'b0;
      d.illegal = 1'b0;
      d.prefetch = 1'b0;
    end
    if (recog && taken) begin
      d.taken_cnt = q.taken_cnt + `PBD_CNT_ONE;
    end
    ev = 3'h0;
    ev[`PBD_EV_ILLEGAL] = recog && dif.illegal;
    ev[`PBD_EV_TAKEN] = recog && taken;
    ev[`PBD_EV_ANNUL] = recog && !dif.illegal && d.annul;
    // one wait cycle: request seen, then answered with waitrequest low
    bus_go = (avs_read || avs_write) && !q.waitreq;
    rd_clr = 3'h0;
    rdata = 32'h0;
    unique case (avs_address)
      `PBD_ADDR_CTRL: rdata = {30'h0, q.ctrl};
      `PBD_ADDR_STATUS: rdata = {29'h0, q.status};
      `PBD_ADDR_MASK: rdata = {29'h0, q.mask};
      `PBD_ADDR_COUNT: rdata = q.taken_cnt;
      default: rdata = 32'h0;
    endcase
    if (avs_read || avs_write) begin
      d.waitreq = !q.waitreq;
    end else begin
      d.waitreq = 1'b1;
    end
    if ((avs_read || avs_write) && q.waitreq) begin
      d.readdata = avs_read ? rdata : 32'h0;
    end
    if (bus_go && avs_write) begin
      unique case (avs_address)
        `PBD_ADDR_CTRL: d.ctrl = avs_writedata[1:0];
        `PBD_ADDR_MASK: d.mask = avs_writedata[2:0];
        default: d.ctrl = q.ctrl;
      endcase
    end
    if (bus_go && avs_read && avs_address == `PBD_ADDR_STATUS) begin
      rd_clr = q.status;
    end
    // a new event in the clearing cycle survives the read
    d.status = (q.status & ~rd_clr) | ev;
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.ctrl <= `PBD_CTRL_RST;
      q.mask <= `PBD_MASK_RST;
      q.waitreq <= 1'b1;
    end else if (clk_en) begin
      q <= d;
    end
  end

  assign avs_readdata = q.readdata;
  assign avs_waitrequest = q.waitreq;
  assign res_valid = q.res_valid;
  assign br_taken = q.taken;
  assign br_target = q.target;
  assign annul_delay = q.annul;
  assign predict_hint = q.hint;
  assign illegal_trap = q.illegal;
  assign prefetch_hint = q.prefetch;
  assign source_register_index = q.src_idx;
  assign irq = q.irq;
endmodule : pbd_top
`default_nettype wire

// ===== pbd_map.svh
// address map, field positions, reset values and encodings of the branch decoder
// Functional notes
// - flag-set select 00 picks the 32-bit flags, 10 the 64-bit flags
// - flag-branch with low select bit set raises the illegal trap
// - signed tests: 1010 greater, 0010 less-equal, 1011 greater-equal, 0011 less
// - unsigned tests: 1100 above, 0100 below-equal, 1101 carry clear, 0101 carry set
// - single flags: 1001/0001 zero, 1110/0110 negative, 1111/0111 overflow
// - always variant jumps to pc plus four times offset; annul bit annuls delay
// - never variant never jumps; annul bit annuls; target usable as prefetch hint
// - true conditional branch jumps and always executes the delay instruction
// - false conditional branch falls through; annul bit annuls the delay instruction
// - prediction bit is only a hint, never changes outcome
// - flag-branch word: op 00, annul, cond, minor 001, selects, predict, 19-bit offset
// - register-branch word layout with bit 28 zero and minor opcode 011
// - register tests signed: zero, at most zero, negative, and inverses
// - register-branch word with bit 28 set raises the illegal trap
// - register tests use all 64 bits; target from upper and lower offsets
// - reserved register tests trap; taken executes delay, untaken annuls if set
`ifndef PBD_MAP_SVH
`define PBD_MAP_SVH
`define PBD_OP_HI 31
`define PBD_OP_LO 30
`define PBD_OP_BRANCH 2'h0
`define PBD_ANNUL_BIT 29
`define PBD_COND_HI 28
`define PBD_COND_LO 25
`define PBD_RSV_BIT 28
`define PBD_RCOND_HI 27
`define PBD_RCOND_LO 25
`define PBD_MINOR_HI 24
`define PBD_MINOR_LO 22
`define PBD_MINOR_FLAG 3'h1
`define PBD_MINOR_REG 3'h3
`define PBD_SEL_HIGH_BIT 21
`define PBD_SEL_LOW_BIT 20
`define PBD_PREDICT_BIT 19
`define PBD_OFS19_HI 18
`define PBD_OFS19_LO 0
`define PBD_OFSUP_HI 21
`define PBD_OFSUP_LO 20
`define PBD_OFSLO_HI 13
`define PBD_OFSLO_LO 0
`define PBD_SRC_HI 18
`define PBD_SRC_LO 14
`define PBD_FLAG_N 3
`define PBD_FLAG_Z 2
`define PBD_FLAG_V 1
`define PBD_FLAG_C 0
`define PBD_COND_NEVER 3'h0
`define PBD_RTEST_RSV 2'h0
`define PBD_RTEST_ZERO 2'h1
`define PBD_RTEST_LEZ 2'h2
`define PBD_REG_SIGN 63
`define PBD_ADDR_CTRL 3'h0
`define PBD_ADDR_STATUS 3'h1
`define PBD_ADDR_MASK 3'h2
`define PBD_ADDR_COUNT 3'h3
`define PBD_CTRL_EN 0
`define PBD_CTRL_PF 1
`define PBD_CTRL_RST 2'h3
`define PBD_EV_ILLEGAL 0
`define PBD_EV_TAKEN 1
`define PBD_EV_ANNUL 2
`define PBD_MASK_RST 3'h0
`define PBD_CNT_ONE 32'h1
`endif

// ===== pbd_pkg.sv
// types and shared arithmetic of the branch decoder
package pbd_pkg;
  typedef logic [31:0] pbd_word_t;
  typedef logic [63:0] pbd_addr_t;
  typedef struct packed {
    logic res_valid;
    logic taken;
    pbd_addr_t target;
    logic annul;
    logic hint;
    logic illegal;
    logic prefetch;
    logic [4:0] src_idx;
    logic [1:0] ctrl;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] taken_cnt;
    logic waitreq;
    logic [31:0] readdata;
    logic irq;
  } pbd_state_s;
  // word offset to a byte offset of full address width
  function automatic pbd_addr_t pbd_word_ofs(input logic [18:0] ofs, input logic wide);
    logic [63:0] ext;
    ext = wide ? {{48{ofs[15]}}, ofs[15:0]} : {{45{ofs[18]}}, ofs};
    return {ext[61:0], 2'h0};
  endfunction : pbd_word_ofs
endpackage : pbd_pkg

// ===== pbd_dec_if.sv
// carries the instruction and its decode between the decoder pieces
`timescale 1ns/10ps
`default_nettype none
interface pbd_dec_if;
  import pbd_pkg::*;
  pbd_word_t word;
  pbd_addr_t pc;
  logic [3:0] flags32;
  logic [3:0] flags64;
  logic [63:0] reg_val;
  logic is_flag;
  logic is_reg;
  logic cond_true;
  logic illegal;
  pbd_addr_t target;
  modport top (output word, pc, flags32, flags64, reg_val,
               input is_flag, is_reg, cond_true, illegal, target);
  modport eval (input word, flags32, flags64, reg_val,
                output is_flag, is_reg, cond_true, illegal);
  modport tgt (input word, pc, is_reg, output target);
endinterface : pbd_dec_if
`default_nettype wire

// ===== pbd_cond_eval.sv
// format recognition, condition tests and illegal-word checks
`timescale 1ns/10ps
`default_nettype none
`include "pbd_map.svh"
module pbd_cond_eval
  import pbd_pkg::*;
(
  pbd_dec_if.eval dif
);
  logic [3:0] f;
  logic r;
  logic rv_zero;
  logic rv_neg;
  always_comb begin
    dif.is_flag = dif.word[`PBD_OP_HI:`PBD_OP_LO] == `PBD_OP_BRANCH &&
                  dif.word[`PBD_MINOR_HI:`PBD_MINOR_LO] == `PBD_MINOR_FLAG;
    dif.is_reg = dif.word[`PBD_OP_HI:`PBD_OP_LO] == `PBD_OP_BRANCH &&
                 dif.word[`PBD_MINOR_HI:`PBD_MINOR_LO] == `PBD_MINOR_REG;
    f = dif.word[`PBD_SEL_HIGH_BIT] ? dif.flags64 : dif.flags32;
    rv_zero = dif.reg_val == 64'h0;
    rv_neg = dif.reg_val[`PBD_REG_SIGN];
    r = 1'b0;
    if (dif.is_reg) begin
      unique case (dif.word[`PBD_RCOND_LO+1:`PBD_RCOND_LO])
        `PBD_RTEST_RSV: r = 1'b0;
        `PBD_RTEST_ZERO: r = rv_zero;
        `PBD_RTEST_LEZ: r = rv_neg | rv_zero;
        default: r = rv_neg;
      endcase
      dif.cond_true = dif.word[`PBD_RCOND_HI] ? ~r : r;
      dif.illegal = dif.word[`PBD_RSV_BIT] ||
                    dif.word[`PBD_RCOND_LO+1:`PBD_RCOND_LO] == `PBD_RTEST_RSV;
    end else begin
      // the high cond bit inverts the sense, so 1000 is the always case
      unique case (dif.word[`PBD_COND_HI-1:`PBD_COND_LO])
        3'h0: r = 1'b0;
        3'h1: r = f[`PBD_FLAG_Z];
        3'h2: r = f[`PBD_FLAG_Z] | (f[`PBD_FLAG_N] ^ f[`PBD_FLAG_V]);
        3'h3: r = f[`PBD_FLAG_N] ^ f[`PBD_FLAG_V];
        3'h4: r = f[`PBD_FLAG_C] | f[`PBD_FLAG_Z];
        3'h5: r = f[`PBD_FLAG_C];
        3'h6: r = f[`PBD_FLAG_N];
        3'h7: r = f[`PBD_FLAG_V];
      endcase
      dif.cond_true = dif.word[`PBD_COND_HI] ? ~r : r;
      dif.illegal = dif.is_flag && dif.word[`PBD_SEL_LOW_BIT];
    end
  end
endmodule : pbd_cond_eval
`default_nettype wire

// ===== pbd_target.sv
// pc-relative target of either branch format
`timescale 1ns/10ps
`default_nettype none
`include "pbd_map.svh"
module pbd_target
  import pbd_pkg::*;
(
  pbd_dec_if.tgt dif
);
  logic [18:0] ofs;
  always_comb begin
    if (dif.is_reg) begin
      ofs = {3'h0, dif.word[`PBD_OFSUP_HI:`PBD_OFSUP_LO], dif.word[`PBD_OFSLO_HI:`PBD_OFSLO_LO]};
    end else begin
      ofs = dif.word[`PBD_OFS19_HI:`PBD_OFS19_LO];
    end
    dif.target = dif.pc + pbd_word_ofs(ofs, dif.is_reg);
  end
endmodule : pbd_target
`default_nettype wire

// ===== pbd_regfile.sv
// register file model that feeds the decoder its source register
`timescale 1ns/10ps
`default_nettype none
module pbd_regfile (
  input wire logic [4:0] index,
  output logic [63:0] value
);
  // sign bit alone and bit 32 alone catch a narrow compare
  always_comb begin
    case (index)
      5'h0: value = 64'h0;
      5'h1: value = 64'hffffffffffffffff;
      5'h2: value = 64'h8000000000000000;
      5'h3: value = 64'h0000000100000000;
      default: value = {59'h0, index};
    endcase
  end
endmodule : pbd_regfile
`default_nettype wire

// ===== pbd_top_chk.sv
// port checks of the branch decoder
`timescale 1ns/10ps
`default_nettype none
module pbd_top_chk (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [2:0] avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic res_valid,
  input wire logic br_taken,
  input wire logic annul_delay,
  input wire logic predict_hint,
  input wire logic illegal_trap,
  input wire logic prefetch_hint
);
  logic br;
  logic fl;
  logic en_q;
  // shadow of the decode enable, followed from accepted control writes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= 1'b1;
    end else if (clk_en && avs_write && !avs_waitrequest && avs_address == 3'h0) begin
      en_q <= avs_writedata[0];
    end
  end
  assign br = clk_en && en_q && instr_valid && instr_word[31:30] == 2'h0 &&
              instr_word[22] && !instr_word[24];
  assign fl = br && !instr_word[23] && !instr_word[20];
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  resp_next_a: assert property (br |=> res_valid)
    else $error("no result after branch word");
  no_spur_a: assert property (clk_en && !br |=> !res_valid)
    else $error("result without branch word");
  sel_trap_a: assert property (br && !instr_word[23] && instr_word[20] |=> illegal_trap)
    else $error("reserved flag select not trapped");
  bit_trap_a: assert property (br && instr_word[23] && instr_word[28] |=> illegal_trap)
    else $error("bit 28 not trapped");
  rtest_trap_a: assert property (br && instr_word[23] && instr_word[26:25] == 2'h0 |=> illegal_trap)
    else $error("reserved register test not trapped");
  trap_quiet_a: assert property (res_valid && illegal_trap |-> !br_taken && !annul_delay && !prefetch_hint)
    else $error("trapped branch acted");
  always_jump_a: assert property (fl && instr_word[28:25] == 4'h8 |=> br_taken && annul_delay == $past(instr_word[29]))
    else $error("always variant wrong");
  never_stay_a: assert property (fl && instr_word[28:25] == 4'h0 |=> !br_taken && annul_delay == $past(instr_word[29]))
    else $error("never variant wrong");
  taken_exec_a: assert property (res_valid && br_taken && ($past(instr_word[23]) || $past(instr_word[27:25]) != 3'h0) |-> !annul_delay)
    else $error("taken branch annulled delay");
  hint_copy_a: assert property (res_valid |-> predict_hint == $past(instr_word[19]))
    else $error("hint differs from word");
  wait_one_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule : pbd_top_chk
bind pbd_top pbd_top_chk u_chk (.clock, .sys_rst, .clk_en, .instr_valid, .instr_word, .avs_read,
  .avs_write, .avs_address, .avs_writedata, .avs_waitrequest, .res_valid, .br_taken,
  .annul_delay, .predict_hint,
  .illegal_trap, .prefetch_hint);
`default_nettype wire

// ===== pbd_top_tb.sv
// self-checking bench of the branch decoder
`timescale 1ns/10ps
`default_nettype none
`define CK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin err_count++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module pbd_top_tb;
  logic clock = 1'b0, sys_rst = 1'b1, instr_valid = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [2:0] avs_address = 3'h0;
  logic [31:0] instr_word = 32'h0, avs_writedata = 32'h0, avs_readdata, rd;
  logic [63:0] instr_pc = 64'h0000001234567000, reg_value, br_target;
  logic [3:0] flags32 = 4'h0, flags64 = 4'h0;
  logic [4:0] source_register_index;
  logic avs_waitrequest, res_valid, br_taken, annul_delay, predict_hint, illegal_trap;
  logic prefetch_hint, irq, pf = 1'b1, clk_en = 1'b1;
  int err_count = 0, samples_checked = 0, cyc = 0, ntk = 0;
  pbd_top dut (.clock, .sys_rst, .clk_en, .instr_valid, .instr_word, .instr_pc, .flags32,
    .flags64, .reg_value, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .res_valid, .br_taken, .br_target, .annul_delay, .predict_hint,
    .illegal_trap, .prefetch_hint, .source_register_index, .irq);
  pbd_regfile u_rf (.index(instr_word[18:14]), .value(reg_value));
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  function automatic logic ok(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[2:0])
      3'h0: r = 1'b0;
      3'h1: r = f[2];
      3'h2: r = f[2] | (f[3] ^ f[1]);
      3'h3: r = f[3] ^ f[1];
      3'h4: r = f[0] | f[2];
      3'h5: r = f[0];
      3'h6: r = f[3];
      default: r = f[1];
    endcase
    return r ^ c[3];
  endfunction : ok
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // only the bench timeout ends a wait that never gets an answer
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic iss(input logic [31:0] w, input logic [3:0] fa, input logic [3:0] fb);
    logic t, il, rg;
    logic [63:0] tg;
    @(posedge clock);
    instr_word <= w;
    flags32 <= fa;
    flags64 <= fb;
    instr_valid <= 1'b1;
    @(posedge clock);
    instr_valid <= 1'b0;
    #1;
    rg = w[23];
    il = rg ? w[28] || w[26:25] == 2'h0 : w[20];
    t = !il && (rg ? ok({w[27], 1'b0, w[26:25]}, {reg_value[63], reg_value == 64'h0, 2'h0})
      : ok(w[28:25], w[21] ? fb : fa));
    tg = instr_pc + (rg ? {{46{w[21]}}, w[21:20], w[13:0], 2'h0} : {{43{w[18]}}, w[18:0], 2'h0});
    if (t)
      ntk++;
    `CK("vld", 1'b1, res_valid)
    `CK("ill", il, illegal_trap)
    `CK("tkn", t, br_taken)
    `CK("anl", !il && w[29] && (!t || !rg && w[28:25] == 4'h8), annul_delay)
    `CK("hnt", w[19], predict_hint)
    `CK("pfh", !il && pf && !rg && w[28:25] == 4'h0, prefetch_hint)
    if (!il) `CK("tgt", tg, br_target)
    `CK("src", rg ? w[18:14] : 5'h0, source_register_index)
  endtask : iss
  task automatic t_flag();
    logic [3:0] f;
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 16; c++)
        for (int i = 0; i < 16; i++) begin
          f = 4'(i);
          iss({2'h0, f[0] ^ c[0], 4'(c), 3'h1, 2'(s), f[1], f, 4'(c), 11'h155}, s[1] ? ~f : f, s[1] ? f : ~f);
        end
  endtask : t_flag
  task automatic t_reg();
    for (int k = 0; k < 16; k++)
      for (int i = 0; i < 5; i++)
        iss({2'h0, k[0] ^ i[0], 4'(k), 3'h3, i[0], 1'b1, i[1], 5'(i), 4'(k), 10'h2a5}, 4'h0, 4'h0);
  endtask : t_reg
  // a branch word while frozen (ce low) or while decode is off must give no result
  task automatic t_off(input logic ce);
    @(posedge clock);
    clk_en <= ce;
    instr_word <= 32'h10400000;
    instr_valid <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CK("refused", 1'b0, res_valid)
    `CK("no jump", 1'b0, br_taken)
    @(posedge clock);
    clk_en <= 1'b1;
    instr_valid <= 1'b0;
  endtask : t_off
  task automatic t_irq();
    bus(1'b0, 3'h3, 32'h0);
    `CK("count", 32'(ntk), rd)
    bus(1'b0, 3'h1, 32'h0);
    bus(1'b0, 3'h1, 32'h0);
    `CK("stat clr", 32'h0, rd)
    iss(32'h02500000, 4'h0, 4'h0);
    `CK("irq off", 1'b0, irq)
    bus(1'b1, 3'h2, 32'h1);
    repeat (2) @(posedge clock);
    #1;
    `CK("irq on", 1'b1, irq)
    bus(1'b0, 3'h1, 32'h0);
    `CK("stat", 32'h1, rd)
    repeat (2) @(posedge clock);
    #1;
    `CK("irq clr", 1'b0, irq)
    bus(1'b1, 3'h0, 32'h1);
    pf = 1'b0;
    iss(32'h20480000, 4'h0, 4'h0);
    bus(1'b1, 3'h0, 32'h0);
    t_off(1'b1);
  endtask : t_irq
  initial begin
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    bus(1'b0, 3'h0, 32'h0);
    `CK("ctrl", 32'h3, rd)
    bus(1'b0, 3'h2, 32'h0);
    `CK("mask", 32'h0, rd)
    bus(1'b1, 3'h7, 32'hffffffff);
    bus(1'b0, 3'h7, 32'h0);
    `CK("unmapped", 32'h0, rd)
    t_flag();
    t_reg();
    t_off(1'b0);
    t_irq();
    report_and_stop();
  end
endmodule : pbd_top_tb
`default_nettype wire
